// ---- rtl/sio_stream_units.sv ----
// stream input and stream output function units, one copy per stream
// assumes the core holds triggers low while lock_o is high; pins synchronous
`timescale 1ns/10ps
`default_nettype none
module sio_stream_units
#(
	// cycles from a sample request to its done pulse; the stage counter holds up to 4
	parameter int SAMPLE_LAT = sio_pkg::SAMPLE_LAT
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// core side, input unit
	input wire sio_pkg::sio_cmd_t in_cmd_i,
	output var sio_pkg::sio_res_t in_res_o,
	output logic in_lock_o,
	// core side, output unit
	input wire sio_pkg::sio_cmd_t out_cmd_i,
	output var sio_pkg::sio_res_t out_res_o,
	output logic out_lock_o,
	// stream source pins
	input wire logic [7:0] src_data_i,
	input wire logic src_status_i,
	output logic src_ack_o,
	// stream sink pins
	output logic [7:0] snk_data_o,
	output logic byte_valid_strobe_o,
	input wire logic snk_status_i
);
	////////////////////////////////////////////////////////////////////////
	// elaboration checks
	// the stage counter is two bits wide, so at most four cycles fit;
	// a one-cycle sample op would leave the stream no time to reply
	if (SAMPLE_LAT < 2 || SAMPLE_LAT > 4)
	begin : g_lat_check
		$error("sample latency outside 2 to 4 cycles");
	end
	// last counter stage, the one that raises done
	localparam logic [1:0] LAST_STAGE = 2'(SAMPLE_LAT - 1);

	////////////////////////////////////////////////////////////////////////
	// decode
	// a sample op waits in WAIT while the stream is empty or full
	sio_pkg::sio_state_t in_st_q, in_st_d; // input unit state
	sio_pkg::sio_state_t out_st_q, out_st_d; // output unit state
	logic [1:0] in_cnt_q, in_cnt_d; // input latency stage
	logic [1:0] out_cnt_q, out_cnt_d; // output latency stage
	sio_pkg::sio_res_t in_res_d, out_res_d; // next result words
	logic [7:0] snk_data_d; // next byte on the sink pins
	logic in_ready, out_ready; // stream can serve
	logic in_fire, out_fire; // transfer starts this cycle
	logic in_last, out_last; // last latency stage, done follows
	// stream can serve now
	assign in_ready = src_status_i;
	assign out_ready = snk_status_i;
	// start the transfer when request is seen and stream ready
	assign in_fire = (in_st_q == sio_pkg::SIO_IDLE && in_cmd_i.sample_go && in_ready)
		|| (in_st_q == sio_pkg::SIO_WAIT && in_ready);
	assign out_fire = (out_st_q == sio_pkg::SIO_IDLE && out_cmd_i.sample_go && out_ready)
		|| (out_st_q == sio_pkg::SIO_WAIT && out_ready);
	assign in_last = in_st_q == sio_pkg::SIO_BUSY && in_cnt_q == LAST_STAGE;
	assign out_last = out_st_q == sio_pkg::SIO_BUSY && out_cnt_q == LAST_STAGE;
	// a sample request that arrives while busy or waiting is dropped;
	// the core is expected to wait for done before it asks again

	// next state, shared form for both units
	function automatic sio_pkg::sio_state_t nxt(input sio_pkg::sio_state_t s,
		input logic go, input logic fire, input logic last);
		case (s)
			sio_pkg::SIO_IDLE: nxt = fire ? sio_pkg::SIO_BUSY
				: (go ? sio_pkg::SIO_WAIT : sio_pkg::SIO_IDLE);
			sio_pkg::SIO_WAIT: nxt = fire ? sio_pkg::SIO_BUSY : sio_pkg::SIO_WAIT;
			sio_pkg::SIO_BUSY: nxt = last ? sio_pkg::SIO_IDLE : sio_pkg::SIO_BUSY;
			default: nxt = sio_pkg::SIO_IDLE;
		endcase
	endfunction : nxt

	assign in_st_d = nxt(in_st_q, in_cmd_i.sample_go, in_fire, in_last);
	assign out_st_d = nxt(out_st_q, out_cmd_i.sample_go, out_fire, out_last);
	// latency counters: fire loads the first stage, done follows the last
	assign in_cnt_d = in_fire ? sio_pkg::STAGE_FIRST
		: in_st_q == sio_pkg::SIO_BUSY ? in_cnt_q + 2'h1
		: sio_pkg::STAGE_IDLE;
	assign out_cnt_d = out_fire ? sio_pkg::STAGE_FIRST
		: out_st_q == sio_pkg::SIO_BUSY ? out_cnt_q + 2'h1
		: sio_pkg::STAGE_IDLE;
	// input result: captured byte or status level
	// limitation: a status query while a read is in flight gets no answer
	always_comb
	begin
		in_res_d = '0;
		if (in_fire)
		begin
			in_res_d.value = src_data_i;
		end
		else if (in_st_q == sio_pkg::SIO_BUSY)
		begin
			in_res_d.value = in_res_o.value; // hold captured byte
			in_res_d.done = in_last;
		end
		else if (in_cmd_i.status_go)
		begin
			in_res_d.value = {7'h00, src_status_i};
			in_res_d.done = 1'b1;
		end
	end
	// output result: status only, writes return done
	always_comb
	begin
		out_res_d = '0;
		if (out_st_q == sio_pkg::SIO_BUSY)
		begin
			out_res_d.done = out_last;
		end
		else if (out_cmd_i.status_go && !out_fire)
		begin
			out_res_d.value = {7'h00, snk_status_i};
			out_res_d.done = 1'b1;
		end
	end
	// sink data is held between writes
	assign snk_data_d = (out_st_q == sio_pkg::SIO_IDLE && out_cmd_i.sample_go)
		? out_cmd_i.wr_byte : snk_data_o;

	////////////////////////////////////////////////////////////////////////
	// registers
	// trade-off: write byte latched at request, so core need not hold it
	// every output of the block comes straight from this one process
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			in_st_q <= sio_pkg::SIO_IDLE;
			out_st_q <= sio_pkg::SIO_IDLE;
			in_cnt_q <= sio_pkg::STAGE_IDLE;
			out_cnt_q <= sio_pkg::STAGE_IDLE;
			in_res_o <= '0;
			out_res_o <= '0;
			src_ack_o <= 1'b0;
			byte_valid_strobe_o <= 1'b0;
			snk_data_o <= sio_pkg::DATA_RST;
			in_lock_o <= 1'b0;
			out_lock_o <= 1'b0;
		end
		else
		begin
			in_st_q <= in_st_d;
			out_st_q <= out_st_d;
			in_cnt_q <= in_cnt_d;
			out_cnt_q <= out_cnt_d;
			in_res_o <= in_res_d;
			out_res_o <= out_res_d;
			src_ack_o <= in_fire;
			byte_valid_strobe_o <= out_fire;
			snk_data_o <= snk_data_d;
			in_lock_o <= in_st_d == sio_pkg::SIO_WAIT;
			out_lock_o <= out_st_d == sio_pkg::SIO_WAIT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks; a second stream is a second instance
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
		src_ack_o |=> !src_ack_o) else $error("ack longer than one cycle");
	a_dv_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
		byte_valid_strobe_o |=> !byte_valid_strobe_o) else $error("valid too long");
	a_in_lat: assert property (@(posedge clk_i) disable iff (reset_i)
		in_fire |-> ##SAMPLE_LAT in_res_o.done) else $error("read latency wrong");
	a_out_lat: assert property (@(posedge clk_i) disable iff (reset_i)
		out_fire |-> ##SAMPLE_LAT out_res_o.done) else $error("write latency wrong");
	a_in_status: assert property (@(posedge clk_i) disable iff (reset_i)
		(in_st_q == sio_pkg::SIO_IDLE && !in_cmd_i.sample_go && in_cmd_i.status_go)
		|=> in_res_o.done && in_res_o.value == {7'h00, $past(src_status_i)})
		else $error("input status wrong");
	a_out_status: assert property (@(posedge clk_i) disable iff (reset_i)
		(out_st_q == sio_pkg::SIO_IDLE && !out_cmd_i.sample_go && out_cmd_i.status_go)
		|=> out_res_o.done && out_res_o.value == {7'h00, $past(snk_status_i)})
		else $error("output status wrong");
	a_in_capture: assert property (@(posedge clk_i) disable iff (reset_i)
		in_fire |=> src_ack_o && in_res_o.value == $past(src_data_i))
		else $error("byte not captured with ack");
	a_out_drive: assert property (@(posedge clk_i) disable iff (reset_i)
		byte_valid_strobe_o |-> snk_data_o == $past(out_cmd_i.wr_byte, 1)
		|| $past(out_st_q) == sio_pkg::SIO_WAIT) else $error("write byte lost");
	a_in_stall: assert property (@(posedge clk_i) disable iff (reset_i)
		(in_st_q == sio_pkg::SIO_IDLE && in_cmd_i.sample_go && !src_status_i)
		|=> in_lock_o && !src_ack_o) else $error("empty read not stalled");
	a_out_stall: assert property (@(posedge clk_i) disable iff (reset_i)
		(out_st_q == sio_pkg::SIO_IDLE && out_cmd_i.sample_go && !snk_status_i)
		|=> out_lock_o && !byte_valid_strobe_o) else $error("full write not stalled");
	// a stall must end on the first cycle the stream can serve again
	a_in_release: assert property (@(posedge clk_i) disable iff (reset_i)
		in_lock_o && src_status_i |=> !in_lock_o && src_ack_o)
		else $error("read not resumed when data came");
	a_out_release: assert property (@(posedge clk_i) disable iff (reset_i)
		out_lock_o && snk_status_i |=> !out_lock_o && byte_valid_strobe_o)
		else $error("write not resumed when room came");
	a_in_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		in_st_q == sio_pkg::SIO_BUSY |=> in_res_o.value == $past(in_res_o.value))
		else $error("read byte changed before done");
	a_snk_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		out_st_q != sio_pkg::SIO_IDLE |=> $stable(snk_data_o))
		else $error("sink byte changed in flight");
	// no disable here: strobes, locks and done must stay low while reset is held
	a_reset_quiet: assert property (@(posedge clk_i)
		reset_i |=> !src_ack_o && !byte_valid_strobe_o && !in_lock_o && !out_lock_o
		&& !in_res_o.done && !out_res_o.done)
		else $error("strobe, lock or done high after reset");
	c_read: cover property (@(posedge clk_i) disable iff (reset_i) src_ack_o ##2 in_res_o.done);
	c_write: cover property (@(posedge clk_i) disable iff (reset_i) byte_valid_strobe_o);
	c_in_stall: cover property (@(posedge clk_i) disable iff (reset_i) in_lock_o ##1 !in_lock_o);
	c_out_stall: cover property (@(posedge clk_i) disable iff (reset_i) out_lock_o ##1 !out_lock_o);
	// end of the input stream seen by a status query
	c_in_empty: cover property (@(posedge clk_i) disable iff (reset_i)
		in_res_o.done && !src_ack_o && in_res_o.value == 8'h00);
endmodule : sio_stream_units
`default_nettype wire

// ---- rtl/sio_pkg.sv ----
// shared constants and carrier types for the stream in/out function units
// assumes a single 10 MHz clock and synchronous active-high reset
`default_nettype none
package sio_pkg;
	// data byte width on the stream pins
	localparam int DATA_W = 8;
	// operation latencies in cycles
	localparam int SAMPLE_LAT = 3;
	localparam int STATUS_LAT = 1;
	// pipeline stage counter width
	localparam int STAGE_W = 2;
	// reset values
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [1:0] STAGE_IDLE = 2'h0;
	// stage loaded on the cycle a transfer starts
	localparam logic [1:0] STAGE_FIRST = 2'h1;
	localparam logic [1:0] STAGE_LAST = 2'h2;
	// trigger from the core for one unit
	typedef struct packed {
		logic sample_go;
		logic status_go;
		logic [7:0] wr_byte;
	} sio_cmd_t;
	// result back to the core
	typedef struct packed {
		logic done;
		logic [7:0] value;
	} sio_res_t;
	// unit states
	typedef enum logic [1:0] {SIO_IDLE, SIO_BUSY, SIO_WAIT} sio_state_t;
endpackage : sio_pkg
`default_nettype wire

// ---- tb/sio_far_model.sv ----
// far side model: byte source and byte sink on the stream pins
// assumes the bench steers avail_i and full_i just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module sio_far_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// bench controls
	input wire logic avail_i,
	input wire logic full_i,
	// source pins
	input wire logic ack_i,
	output logic [7:0] data_o,
	output logic status_o,
	// sink pins
	input wire logic [7:0] snk_data_i,
	input wire logic valid_i,
	output logic room_o,
	output var logic [7:0] got_o
);
	logic [7:0] next_q; // byte the source offers
	assign status_o = avail_i;
	assign room_o = !full_i;
	// no data left: show no stale byte
	assign data_o = avail_i ? next_q : ~next_q;
	////////////////////////////////////////
	// ack is a one-cycle pulse, so high here means its rise
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			next_q <= 8'hA0;
		else if (ack_i)
			next_q <= next_q + 8'h01;
		if (valid_i)
			got_o <= snk_data_i;
	end
endmodule : sio_far_model
`default_nettype wire

// ---- tb/sio_stream_units_tb.sv ----
// bench for the stream units against the far side model
// assumes the package is compiled first
`timescale 1ns/10ps
`default_nettype none
module sio_stream_units_tb;
	logic clk = 1'b0, reset = 1'b1, avail = 1'b1, full = 1'b0;
	sio_pkg::sio_cmd_t in_cmd = '0, out_cmd = '0;
	sio_pkg::sio_res_t in_res, out_res;
	logic in_lock, out_lock, ack, stat, valid, room;
	logic [7:0] sdata, odata, got;
	int n_fail = 0, n_tests = 0;
	always #50 clk = ~clk;
	sio_stream_units i_sio_stream_units (.clk_i(clk), .reset_i(reset), .in_cmd_i(in_cmd),
		.in_res_o(in_res), .in_lock_o(in_lock), .out_cmd_i(out_cmd), .out_res_o(out_res),
		.out_lock_o(out_lock), .src_data_i(sdata), .src_status_i(stat), .src_ack_o(ack),
		.snk_data_o(odata), .byte_valid_strobe_o(valid), .snk_status_i(room));
	sio_far_model i_sio_far_model (.clk_i(clk), .reset_i(reset), .avail_i(avail),
		.full_i(full), .ack_i(ack), .data_o(sdata), .status_o(stat), .snk_data_i(odata),
		.valid_i(valid), .room_o(room), .got_o(got));
	////////////////////////////////////////
	// inputs move 1 ns after the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// compare one result
	task automatic chk(input logic [8:0] g, input logic [8:0] e, input string m);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	// sample read, optionally on an empty stream first
	task automatic rd(input logic [7:0] e, input logic stall);
		avail = !stall;
		in_cmd.sample_go = 1'b1;
		step(1);
		in_cmd.sample_go = 1'b0;
		if (stall)
		begin
			step(3);
			chk({7'h00, in_lock, ack}, 9'h002, "read stall");
			avail = 1'b1;
			step(1);
		end
		chk({ack, in_res.value}, {1'b1, e}, "read ack");
		step(1);
		chk({7'h00, ack, in_res.done}, 9'h000, "read gap");
		step(1);
		chk({7'h00, ack, in_res.done}, 9'h001, "read done");
		chk({in_res.done, in_res.value}, {1'b1, e}, "read byte at done");
		step(1);
		$display("read test over");
	endtask : rd
	// sample write, optionally into a full sink first
	task automatic wr(input logic [7:0] b, input logic stall);
		full = stall;
		out_cmd.sample_go = 1'b1;
		out_cmd.wr_byte = b;
		step(1);
		out_cmd.sample_go = 1'b0;
		out_cmd.wr_byte = ~b;
		if (stall)
		begin
			step(3);
			chk({7'h00, out_lock, valid}, 9'h002, "write stall");
			full = 1'b0;
			step(1);
		end
		chk({valid, odata}, {1'b1, b}, "write valid");
		step(1);
		chk({valid, got}, {1'b0, b}, "sink got");
		step(1);
		chk({7'h00, valid, out_res.done}, 9'h001, "write done");
		chk({out_res.done, out_res.value}, {1'b1, 8'h00}, "write result");
		step(1);
		$display("write test over");
	endtask : wr
	// both status queries in one cycle
	task automatic sts(input logic s);
		avail = s;
		full = !s;
		in_cmd.status_go = 1'b1;
		out_cmd.status_go = 1'b1;
		step(1);
		in_cmd.status_go = 1'b0;
		out_cmd.status_go = 1'b0;
		chk({in_res.done, in_res.value}, {1'b1, 7'h00, s}, "in status");
		chk({out_res.done, out_res.value}, {1'b1, 7'h00, s}, "out status");
		step(1);
		chk({7'h00, in_res.done, out_res.done}, 9'h000, "status done once");
		$display("status test over");
	endtask : sts
	// reset in the middle of a stalled read: everything falls quiet
	task automatic rst_mid;
		avail = 1'b0;
		in_cmd.sample_go = 1'b1;
		step(1);
		in_cmd.sample_go = 1'b0;
		step(1);
		chk({7'h00, in_lock, ack}, 9'h002, "stall before reset");
		reset = 1'b1;
		step(2);
		chk({5'h00, in_lock, ack, valid, in_res.done}, 9'h000, "quiet in reset");
		reset = 1'b0;
		$display("mid reset test over");
	endtask : rst_mid
	// verdict and end of run
	task automatic conclude;
		$display("tests %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////
	initial
	begin
		step(10);
		reset = 1'b0;
		chk({7'h00, ack, valid}, 9'h000, "reset");
		rd(8'hA0, 1'b0);
		rd(8'hA1, 1'b0);
		rd(8'hA2, 1'b1);
		wr(8'h5A, 1'b0);
		wr(8'hC3, 1'b1);
		rst_mid();
		rd(8'hA0, 1'b0);
		sts(1'b1);
		sts(1'b0);
		conclude();
	end
	// hang guard, well past the expected length
	initial
	begin
		#100000;
		n_fail++;
		conclude();
	end
endmodule : sio_stream_units_tb
`default_nettype wire
